// File: rtl/eeslv_pkg.sv
// Constants and types shared by the two-wire memory target.
package eeslv_pkg;
  localparam int          ADDR_W          = 14;
  localparam int          DATA_W          = 8;
  localparam int          PAGE_BITS       = 6;
  localparam logic [3:0]  DEV_TYPE_CODE   = 4'hA;
  localparam int          CLK_FREQ_HZ     = 100000000;
  localparam int          PROG_TIME_US    = 5000;
  localparam int          PROG_CYCLES     = (CLK_FREQ_HZ / 1000000) * PROG_TIME_US;
  localparam int          FIFO_DEPTH      = 8;
  localparam logic [13:0] WORD_ADDR_RESET = 14'h0000;
  localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;

  typedef enum logic [2:0] {
    EESLV_IDLE,
    EESLV_DEV,
    EESLV_ADDR_HI,
    EESLV_ADDR_LO,
    EESLV_WDATA,
    EESLV_RDATA,
    EESLV_IGNORE
  } eeslv_state_t;
endpackage

// File: rtl/eeslv_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module eeslv_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  input  wire logic             flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (flush) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: rtl/eeslv_top.sv
// Two-wire serial memory target: bus decoding, array, write buffer and program timer.
// Functional notes
// - Sample data on rising bus clock, change output data on falling bus clock.
// - Data line is only pulled low or released, never driven high.
// - Unconnected select straps read as low when compared.
// - Write-protect high blocks all programming; low allows normal operation.
// - Array holds 16K bytes addressed by 14-bit word address.
// - Data changes only while clock low; changes with clock high are START/STOP.
// - Data falling while clock high is START; START precedes every command.
// - Data rising while clock high is STOP; ends current command.
// - STOP after a read sequence puts device into standby.
// - Words are eight bits; each received word is acknowledged low on ninth clock.
// - Address word top nibble must be 1010 for a response.
// - Next three address bits compare with the three select straps.
// - Eighth address bit selects read when one, write when zero.
// - Match gives low acknowledge; mismatch returns to standby until next START.
// - Programming cycle after a write completes within 5 ms.
// - Page writes up to 64 bytes, partial pages accepted; the write buffer keeps only the first 8 bytes of a page.
// - Write sends two word-address bytes, each acknowledged.
// - Page write increments only low six address bits, wrapping in page.
// - No acknowledge of address word while programming is in progress.
// - Reads increment address and wrap from last location to first.
`timescale 1ns/1ps
module eeslv_top
  import eeslv_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] device_select_straps,
  input  wire logic       write_protect,
  output logic            prog_busy,
  output logic            standby
);
  import eeslv_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] wp_sync;
  logic [2:0] sel_meta;
  logic [2:0] sel_sync;
  logic       scl_d;
  logic       sda_d;

  // Edge registers reset to the idle-high bus level, so that leaving reset
  // cannot look like a START or a clock edge.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync  <= 2'h0;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      wp_sync  <= {wp_sync[0], write_protect};
      sel_meta <= device_select_straps;
      sel_sync <= sel_meta;
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl       = scl_sync[1];
  assign sda       = sda_sync[1];
  assign scl_rise  = scl && !scl_d;
  assign scl_fall  = !scl && scl_d;
  assign start_det = scl && scl_d && sda_d && !sda;
  assign stop_det  = scl && scl_d && !sda_d && sda;

  // ----------------------------------------------------------------
  // Byte framing and protocol state
  // ----------------------------------------------------------------
  eeslv_state_t        state;
  logic [3:0]          bit_cnt;
  logic [DATA_W-1:0]   shreg;
  logic                ack_phase;
  logic                drive_low;
  logic                did_read;
  logic                rd_ack_due;
  logic [ADDR_W-1:0]   word_addr;
  logic [ADDR_W-1:0]   write_base;
  logic                have_writes;
  logic [DATA_W-1:0]   mem [2**ADDR_W];
  logic [DATA_W-1:0]   tx_byte;
  logic [DATA_W-1:0]   rd_data;

  logic byte_done;
  logic dev_match;
  assign byte_done = scl_rise && !ack_phase && (bit_cnt == 4'h7);
  // Floating straps are assumed pulled low by the pad, so the raw level is compared.
  assign dev_match = ({shreg[6:0], sda} >> 4) == {4'h0, DEV_TYPE_CODE}
                     && shreg[2:0] == sel_sync;
  assign rd_data   = mem[word_addr];

  // Write buffer between bus side and array programmer.
  // A page longer than the buffer is still acknowledged, but bytes past its depth are lost.
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  logic [ADDR_W+DATA_W-1:0]  fifo_out_data;
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;
  logic                      fifo_flush;
  logic                      prog_run;
  logic [31:0]               prog_cnt;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= EESLV_IDLE;
      bit_cnt     <= BIT_CNT_RESET;
      shreg       <= '0;
      ack_phase   <= 1'b0;
      did_read    <= 1'b0;
      word_addr   <= WORD_ADDR_RESET;
      write_base  <= WORD_ADDR_RESET;
      have_writes <= 1'b0;
      standby     <= 1'b1;
    end else if (start_det) begin
      state     <= EESLV_DEV;
      bit_cnt   <= BIT_CNT_RESET;
      ack_phase <= 1'b0;
      standby   <= 1'b0;
    end else if (stop_det) begin
      state <= EESLV_IDLE;
      if (did_read) begin
        standby <= 1'b1;
      end
      if (have_writes) begin
        have_writes <= 1'b0;
      end
      did_read <= 1'b0;
    end else if (scl_rise && state != EESLV_IDLE && state != EESLV_IGNORE) begin
      if (ack_phase) begin
        ack_phase <= 1'b0;
        bit_cnt   <= BIT_CNT_RESET;
        // Controller's no-acknowledge ends a read; wait for STOP.
        if (state == EESLV_RDATA && sda) begin
          state <= EESLV_IGNORE;
        end
      end else begin
        shreg   <= {shreg[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
        if (byte_done) begin
          ack_phase <= 1'b1;
          case (state)
            EESLV_DEV: begin
              if (dev_match && !prog_busy) begin
                state    <= sda ? EESLV_RDATA : EESLV_ADDR_HI;
                did_read <= sda;
              end else begin
                state   <= EESLV_IGNORE;
                standby <= 1'b1;
              end
            end
            EESLV_ADDR_HI: begin
              word_addr[13:8] <= {shreg[4:0], sda};
              state           <= EESLV_ADDR_LO;
            end
            EESLV_ADDR_LO: begin
              word_addr[7:0] <= {shreg[6:0], sda};
              state          <= EESLV_WDATA;
            end
            EESLV_WDATA: begin
              // Only the low page bits advance so data wraps inside the page.
              word_addr[PAGE_BITS-1:0] <= word_addr[PAGE_BITS-1:0] + 1'b1;
              have_writes              <= 1'b1;
            end
            EESLV_RDATA: begin
              word_addr <= word_addr + 1'b1;
            end
            default: begin
              state <= EESLV_IGNORE;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read address acknowledge
  // ----------------------------------------------------------------
  // The ninth bit after a read address word is ours to pull low; the ninth bit
  // after every read data byte belongs to the controller and must stay released.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ack_due <= 1'b0;
    end else if (start_det || stop_det) begin
      rd_ack_due <= 1'b0;
    end else if (byte_done && state == EESLV_DEV) begin
      rd_ack_due <= dev_match && !prog_busy && sda;
    end else if (scl_rise && ack_phase) begin
      rd_ack_due <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Data line drive, changed only after a falling bus clock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_low <= 1'b0;
      tx_byte   <= '0;
    end else if (start_det || stop_det || state == EESLV_IDLE || state == EESLV_IGNORE) begin
      drive_low <= 1'b0;
    end else if (scl_fall) begin
      if (ack_phase) begin
        // Every received word is answered; in a read only the address word is.
        drive_low <= (state != EESLV_RDATA) || rd_ack_due;
        tx_byte   <= rd_data;
      end else if (state == EESLV_RDATA && bit_cnt == 4'h0 && !ack_phase) begin
        drive_low <= !rd_data[7];
        tx_byte   <= {rd_data[6:0], 1'b0};
      end else if (state == EESLV_RDATA) begin
        drive_low <= !tx_byte[7];
        tx_byte   <= {tx_byte[6:0], 1'b0};
      end else begin
        drive_low <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= drive_low;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and timed programming
  // ----------------------------------------------------------------
  assign fifo_in_valid  = scl_rise && !ack_phase && byte_done && state == EESLV_WDATA
                          && !start_det && !stop_det;
  assign fifo_flush     = start_det && !prog_busy;
  assign fifo_out_ready = prog_run;

  eeslv_fifo #(
    .WIDTH (ADDR_W + DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .in_data   ({word_addr, shreg[6:0], sda}),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .flush     (fifo_flush)
  );

  // Array is written while the timer runs; protected writes are drained and dropped.
  always_ff @(posedge sys_clk) begin
    if (prog_run && fifo_out_valid && !wp_sync[1]) begin
      mem[fifo_out_data[ADDR_W+DATA_W-1:DATA_W]] <= fifo_out_data[DATA_W-1:0];
    end
  end

  // The busy flag runs its full length even for one byte, so polling sees a fixed cycle.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_run  <= 1'b0;
      prog_cnt  <= '0;
      prog_busy <= 1'b0;
    end else if (stop_det && have_writes && !prog_busy) begin
      prog_run  <= 1'b1;
      prog_cnt  <= '0;
      prog_busy <= 1'b1;
    end else if (prog_busy) begin
      prog_cnt <= prog_cnt + 32'h1;
      if (!fifo_out_valid) begin
        prog_run <= 1'b0;
      end
      if (prog_cnt >= 32'(PROG_CYCLES_P - 1)) begin
        prog_busy <= 1'b0;
        prog_run  <= 1'b0;
      end
    end
  end
endmodule

// File: bench/eeslv_properties.sv
// Pin-level checks on the memory target, bound to its top module.
`timescale 1ns/1ps
module eeslv_properties #(
  parameter int PROG_CYCLES_P = 200
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [2:0] device_select_straps,
  input wire logic       write_protect,
  input wire logic       prog_busy,
  input wire logic       standby
);
  int busy_cnt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // The program timer has no other visible bound, so count its length here.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
    end
  end

  a_never_high: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  a_edge_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data output moved with clock high");
  a_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data output not stable in high phase");
  a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe throughout (##[1:40] $fell(scl_in)))
    else $error("low bit released before clock fall");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("answer given while programming");
  a_busy_bound: assert property (busy_cnt <= PROG_CYCLES_P)
    else $error("program cycle too long");
  a_busy_stop: assert property ($rose(prog_busy) |-> scl_in && sda_in)
    else $error("program cycle began without stop");
  a_reset_idle: assert property ($fell(sys_rst) |-> standby && !prog_busy && !sda_oe)
    else $error("outputs not idle after reset");

  c_busy: cover property ($rose(prog_busy));
  c_ack: cover property ($rose(sda_oe));
  c_wake: cover property ($fell(standby));
endmodule

bind eeslv_top eeslv_properties #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .device_select_straps(device_select_straps),
  .write_protect(write_protect), .prog_busy(prog_busy), .standby(standby)
);

// File: bench/eeslv_host_model.sv
// Behavioural two-wire bus controller for the memory target.
`timescale 1ns/1ps
module eeslv_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  // Both lines rest high and the clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Used only on an idle bus or as a repeated start inside a frame.
  task automatic start();
    q(2);
    sda_drv = 1'b1;
    q(6);
    scl = 1'b1;
    q(8);
    sda_drv = 1'b0;
    q(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    q(2);
    sda_drv = 1'b0;
    q(6);
    scl = 1'b1;
    q(8);
    sda_drv = 1'b1;
    q(8);
  endtask

  // Data moves two cycles after the clock falls so it never races the high phase.
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    logic [8:0] o;
    logic [8:0] r;
    o = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      q(2);
      sda_drv = o[i];
      q(6);
      scl = 1'b1;
      q(8);
      r[i] = sda;
      scl = 1'b0;
    end
    rx = r[8:1];
    ack = !r[0];
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the two-wire memory target.
`timescale 1ns/1ps
module tb;
  import eeslv_pkg::*;
  logic       sys_clk;
  logic       sys_rst;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe;
  logic       prog_busy;
  logic       standby;
  logic       write_protect;
  logic [2:0] straps;
  logic [7:0] rx;
  logic       ack;
  int         failures;
  int         samples_checked;
  int         cycles;
  // Pull-up wire: low while either party pulls it.
  wire        sda = (sda_oe ? sda_out : 1'b1) & sda_drv;

  eeslv_top #(.PROG_CYCLES_P(400)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .device_select_straps(straps),
    .write_protect(write_protect), .prog_busy(prog_busy), .standby(standby)
  );
  eeslv_host_model host (.clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic e);
    host.xfer(b, 1'b1, rx, ack);
    chk({7'h0, ack}, {7'h0, e}, "ack");
  endtask

  task automatic hdr(input logic [13:0] a);
    host.start();
    send({DEV_TYPE_CODE, straps, 1'b0}, 1'b1);
    send({2'h0, a[13:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 2000 && prog_busy !== 1'b0; i++) @(negedge sys_clk);
    chk({7'h0, prog_busy}, 8'h00, "busy end");
  endtask

  task automatic rd2(input logic [13:0] a, input logic [7:0] e0, input logic [7:0] e1);
    hdr(a);
    host.start();
    send({DEV_TYPE_CODE, straps, 1'b1}, 1'b1);
    host.xfer(8'hFF, 1'b0, rx, ack);
    chk(rx, e0, "read 0");
    host.xfer(8'hFF, 1'b1, rx, ack);
    chk(rx, e1, "read 1");
    host.stop();
    chk({7'h0, standby}, 8'h01, "standby");
  endtask

  task automatic t_page();
    hdr(14'h3FFE);
    chk({7'h0, standby}, 8'h00, "awake");
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    send(8'h44, 1'b1);
    host.stop();
    chk({7'h0, prog_busy}, 8'h01, "busy start");
    host.start();
    send({DEV_TYPE_CODE, straps, 1'b0}, 1'b0);
    host.stop();
    wait_idle();
    $display("t_page done");
  endtask

  task automatic t_protect();
    hdr(14'h0000);
    send(8'h5A, 1'b1);
    host.stop();
    wait_idle();
    write_protect = 1'b1;
    hdr(14'h3FC0);
    send(8'hEE, 1'b1);
    host.stop();
    wait_idle();
    write_protect = 1'b0;
    rd2(14'h3FFF, 8'h22, 8'h5A);
    rd2(14'h3FC0, 8'h33, 8'h44);
    $display("t_protect done");
  endtask

  // A match leaves the target waiting, so a repeated start moves on.
  task automatic t_straps();
    straps = 3'h5;
    host.start();
    for (int s = 0; s < 8; s++) begin
      send({DEV_TYPE_CODE, s[2:0], 1'b0}, logic'(s == 5));
      host.start();
    end
    send({4'h5, straps, 1'b0}, 1'b0);
    chk({7'h0, standby}, 8'h01, "standby on miss");
    host.stop();
    $display("t_straps done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    straps = 3'h3;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_page();
    t_protect();
    t_straps();
    end_sim();
  end
endmodule
